/* File: scd_pkg.sv */
// Shared constants for the sample clock delay and SYSREF window block.
// Assumes a 32-bit AXI4-Lite register bus and one 20 MHz system clock.
`default_nettype none
package scd_pkg;
    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DELAY = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_FLAGS = 4'hc;
    // Control register field positions
    localparam int CTRL_DUAL = 0;
    localparam int CTRL_INV = 1;
    localparam int CTRL_RAMP_EN = 2;
    localparam int CTRL_RAMP_FAST = 3;
    localparam int CTRL_STEP_FINE = 4;
    localparam int CTRL_SEL_LSB = 8;
    localparam int SEL_W = 4;
    // Delay register field positions
    localparam int DELAY_COARSE_LSB = 0;
    localparam int DELAY_FINE_LSB = 8;
    // Values after reset
    localparam logic [11:0] CTRL_RST = 12'h001;
    localparam logic [15:0] DELAY_RST = 16'h0000;
    // Ramp timing in clock cycles
    localparam int RAMP_PERIOD = 384;
    localparam int RAMP_TICK_W = 9;
    localparam int RAMP_STEP_SLOW = 1;
    localparam int RAMP_STEP_FAST = 4;
    // Window detector
    localparam int NUM_PHASES = 24;
    localparam int MIN_SYSREF_EDGES = 3;
    // Weights of the delay parts in fine units
    localparam int FINE_DELAY_CODE_UNIT = 1;
    localparam int COARSE_DELAY_CODE_UNIT = 16;
    localparam int TAD_HALF_UNIT = 4096;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: scd_ramp.sv */
// Coarse delay ramp: walks the active coarse code toward its target.
// Assumes load is a one-cycle pulse from the register file on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module scd_ramp
    import scd_pkg::*;
#(
    parameter int CODE_W = 8
)(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic load,
    input wire logic ramp_en,
    input wire logic fast,
    input wire logic [CODE_W-1:0] target_in,
    output logic [CODE_W-1:0] active,
    output logic [CODE_W-1:0] target,
    output logic busy
);
    localparam logic [RAMP_TICK_W-1:0] TICK_LAST = RAMP_TICK_W'(RAMP_PERIOD - 1);

    logic [RAMP_TICK_W-1:0] tick; // Cycles since last step
    logic [RAMP_TICK_W-1:0] next_tick;
    logic [CODE_W-1:0] next_active;
    logic [CODE_W-1:0] next_target;
    logic next_busy;

    // Next ramp state
    always_comb
    begin
        logic [CODE_W-1:0] gap;
        logic [CODE_W-1:0] step;
        gap = '0;
        step = '0;
        next_tick = tick;
        next_active = active;
        next_target = target;
        if (load)
        begin
            // New target restarts the step timer
            next_target = target_in; // R15
            next_tick = '0;
            if (!ramp_en)
                next_active = target_in; // R25
        end
        else if (active != target)
        begin
            if (tick == TICK_LAST)
            begin
                // One step per period, clipped to the gap
                next_tick = '0;
                gap = (active < target) ? target - active : active - target;
                step = fast ? CODE_W'(RAMP_STEP_FAST) : CODE_W'(RAMP_STEP_SLOW); // R14
                if (gap < step)
                    step = gap;
                next_active = (active < target) ? active + step : active - step; // R13
            end
            else
                next_tick = tick + 1'b1;
        end
        else
            next_tick = '0; // R24
        next_busy = next_active != next_target;
    end

    // Ramp registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick <= '0;
            active <= '0;
            target <= '0;
            busy <= 1'b0;
        end
        else if (clk_en)
        begin
            tick <= next_tick;
            active <= next_active;
            target <= next_target;
            busy <= next_busy;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    hold_at_target_a: assert property (clk_en && !load && active == target // R24
        |=> active == $past(active)) else $error("Ramp moved at target");
    direct_load_a: assert property (clk_en && load && !ramp_en // R25
        |=> active == $past(target_in)) else $error("Direct load missed");
    fresh_ramp_a: assert property (clk_en && load && ramp_en // R15
        |=> target == $past(target_in) && tick == '0) else $error("Ramp not restarted");
    step_wait_a: assert property (clk_en && !load && tick != TICK_LAST // R14
        |=> active == $past(active)) else $error("Step before period end");
    slow_step_a: assert property (clk_en && !load && !fast && tick == TICK_LAST // R13
        && active < target |=> active == CODE_W'($past(active) + 1'b1))
        else $error("Slow step wrong");
endmodule // scd_ramp
`default_nettype wire

/* File: scd_top.sv */
// Sample clock delay control and SYSREF window detector, AXI4-Lite slave.
// Assumes sysref_in and sysref_taps come from pins, asynchronous to sys_clk.
// Summary of operation
// [R1] Dual mode samples on rising edge only
// [R2] Single mode samples on both edges
// [R3] SYSREF may be pulse or periodic
// [R4] Periodic SYSREF tracks multiframe or multiblock rate
// [R5] 8b/10b SYSREF rate formula with ten
// [R6] 64b/66b SYSREF rate formula with 66x32
// [R7] SYSREF latched on one deterministic edge
// [R8] Invert setting adds half clock delay
// [R9] Coarse and fine codes select 256 steps
// [R10] Delay parts add independently
// [R11] One delay shifts output and SYSREF capture
// [R12] Delay rewritable live, link may realign
// [R13] Ramp steps coarse delay gradually
// [R14] Ramp rate one or four per 384
// [R15] Coarse write with ramp starts new ramp
// [R16] Window measures SYSREF against candidate phases
// [R17] Flags valid after three SYSREF edges
// [R18] Flag set for unsafe phase, clear otherwise
// [R19] Select routes capture through chosen phase
// [R20] Software picks phase midway between violations
// [R21] 24 flags, select reaches first 16
// [R22] Flags 0 and 23 always one; reset clears them until the first SYSREF edge
// [R23] Step field picks coarse or fine spacing
// [R24] Ramp stops and holds at target
// [R25] Ramp off means coarse write applies directly
`timescale 1ns/100ps
`default_nettype none
module scd_top
    import scd_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int PHASES = NUM_PHASES,
    parameter int CODE_W = 8
)(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sysref_in,
    input wire logic [PHASES-1:0] sysref_taps,
    output logic sample_rise_en,
    output logic sample_fall_en,
    output logic clk_delay_invert,
    output logic [CODE_W-1:0] clk_delay_coarse,
    output logic [CODE_W-1:0] clk_delay_fine,
    output logic [15:0] clk_delay_total,
    output logic link_realign,
    output logic window_step_fine,
    output logic sysref_capture
);
    // Register file state
    logic [11:0] ctrl; // Mode, delay and window control
    logic [15:0] delay; // Coarse target and fine code
    logic aw_full; // Write address held
    logic w_full; // Write data held
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic coarse_load; // Pulse to the ramp
    logic [11:0] next_ctrl;
    logic [15:0] next_delay;
    logic next_aw_full;
    logic next_w_full;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_coarse_load;
    logic next_awready;
    logic next_wready;
    logic [1:0] next_bresp;
    logic next_bvalid;
    logic next_arready;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid;
    // Ramp outputs
    logic ramp_busy;
    // Window detector state
    logic sr_s1; // First sync stage, read only by sr_s2
    logic sr_s2;
    logic sr_s3; // Previous level for edge detect
    logic [PHASES-1:0] tap_s1; // First sync stage
    logic [PHASES-1:0] tap_s2;
    logic [PHASES-1:0] tap_last; // Taps at previous edge
    logic [PHASES-1:0] flags; // Unsafe phase flags
    logic [1:0] edge_cnt; // Saturating SYSREF edge count
    logic flags_valid;
    logic [PHASES-1:0] raw_flag;
    logic [PHASES-1:0] next_tap_last;
    logic [PHASES-1:0] next_flags;
    logic [1:0] next_edge_cnt;
    logic next_flags_valid;
    logic next_capture;
    logic sysref_edge;
    // Clock output next values
    logic [15:0] next_total;
    logic next_realign;

    // Register file and AXI4-Lite handshakes
    always_comb
    begin
        logic [31:0] rd;
        logic hit;
        rd = '0;
        hit = 1'b1;
        next_ctrl = ctrl;
        next_delay = delay;
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_coarse_load = 1'b0;
        next_bresp = s_axi_bresp;
        next_bvalid = s_axi_bvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_rvalid = s_axi_rvalid;
        // Retire answers the master has taken
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        // Write once address and data are both held
        if (aw_full && w_full && !s_axi_bvalid)
        begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (aw_addr == ADDR_W'(REG_CTRL))
            begin
                if (w_strb[0])
                    next_ctrl[7:0] = w_data[7:0];
                if (w_strb[1])
                    next_ctrl[11:8] = w_data[11:8];
            end
            else if (aw_addr == ADDR_W'(REG_DELAY))
            begin
                // Live rewrite allowed, link told by realign pulse
                if (w_strb[0])
                begin
                    next_delay[7:0] = w_data[7:0];
                    next_coarse_load = 1'b1; // R12
                end
                if (w_strb[1])
                    next_delay[15:8] = w_data[15:8];
            end
            else if (aw_addr != ADDR_W'(REG_STATUS) && aw_addr != ADDR_W'(REG_FLAGS))
                next_bresp = RESP_SLVERR;
        end
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // Read decode, answered at the address edge
        if (s_axi_arvalid && s_axi_arready)
        begin
            if (s_axi_araddr == ADDR_W'(REG_CTRL))
                rd = {20'h0, ctrl};
            else if (s_axi_araddr == ADDR_W'(REG_DELAY))
                rd = {16'h0, delay};
            else if (s_axi_araddr == ADDR_W'(REG_STATUS))
                rd = {20'h0, edge_cnt, flags_valid, ramp_busy, clk_delay_coarse};
            else if (s_axi_araddr == ADDR_W'(REG_FLAGS))
                rd = 32'(flags);
            else
                hit = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = rd;
            next_rresp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        next_awready = !next_aw_full;
        next_wready = !next_w_full;
        next_arready = !next_rvalid;
    end

    // Register file registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= CTRL_RST;
            delay <= DELAY_RST;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            coarse_load <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_bvalid <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
        end
        else if (clk_en)
        begin
            ctrl <= next_ctrl;
            delay <= next_delay;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            coarse_load <= next_coarse_load;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bresp <= next_bresp;
            s_axi_bvalid <= next_bvalid;
            s_axi_arready <= next_arready;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_rvalid <= next_rvalid;
        end
    end

    // Coarse delay ramp
    scd_ramp #(
        .CODE_W(CODE_W)
    ) u_ramp (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .load(coarse_load),
        .ramp_en(ctrl[CTRL_RAMP_EN]),
        .fast(ctrl[CTRL_RAMP_FAST]),
        .target_in(delay[DELAY_COARSE_LSB +: CODE_W]), // R9
        .active(clk_delay_coarse),
        .target(),
        .busy(ramp_busy)
    );

    // Per phase unsafe test: edge nearby or unstable between SYSREF edges
    assign sysref_edge = sr_s2 & ~sr_s3; // R3
    generate
        for (genvar i = 0; i < PHASES; i++)
        begin : g_flag
            if (i == 0 || i == PHASES - 1)
            begin : g_end
                assign raw_flag[i] = 1'b1; // R22
            end
            else
            begin : g_mid
                assign raw_flag[i] = (tap_s2[i] ^ tap_s2[i-1]) | (tap_s2[i] ^ tap_s2[i+1])
                    | (tap_s2[i] ^ tap_last[i]); // R18
            end
        end
    endgenerate

    // Window detector next values
    always_comb
    begin
        next_tap_last = tap_last;
        next_flags = flags;
        next_edge_cnt = edge_cnt;
        next_capture = 1'b0;
        if (sysref_edge)
        begin
            // Measure all candidate phases at this edge
            next_tap_last = tap_s2;
            next_flags = raw_flag; // R16
            if (edge_cnt != 2'(MIN_SYSREF_EDGES))
                next_edge_cnt = edge_cnt + 1'b1;
            // Selected phase only, index below 16
            next_capture = tap_s2[ctrl[CTRL_SEL_LSB +: SEL_W]]; // R19 R21 R7
        end
        next_flags_valid = next_edge_cnt == 2'(MIN_SYSREF_EDGES); // R17
    end

    // Window detector and synchroniser registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sr_s1 <= 1'b0;
            sr_s2 <= 1'b0;
            sr_s3 <= 1'b0;
            tap_s1 <= '0;
            tap_s2 <= '0;
            tap_last <= '0;
            flags <= '0;
            edge_cnt <= 2'h0;
            flags_valid <= 1'b0;
            sysref_capture <= 1'b0;
        end
        else if (clk_en)
        begin
            sr_s1 <= sysref_in;
            sr_s2 <= sr_s1;
            sr_s3 <= sr_s2;
            tap_s1 <= sysref_taps;
            tap_s2 <= tap_s1;
            tap_last <= next_tap_last;
            flags <= next_flags;
            edge_cnt <= next_edge_cnt;
            flags_valid <= next_flags_valid;
            sysref_capture <= next_capture;
        end
    end

    // Combined delay of invert, coarse and fine parts
    always_comb
    begin
        next_total = (ctrl[CTRL_INV] ? 16'(TAD_HALF_UNIT) : 16'h0) // R8 R10
            + 16'(int'(clk_delay_coarse) * COARSE_DELAY_CODE_UNIT)
            + 16'(int'(delay[DELAY_FINE_LSB +: CODE_W]) * FINE_DELAY_CODE_UNIT);
        next_realign = next_total != clk_delay_total; // R12
    end

    // Clock path outputs; one delay feeds all internal clocks
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample_rise_en <= 1'b0;
            sample_fall_en <= 1'b0;
            clk_delay_invert <= 1'b0;
            clk_delay_fine <= '0;
            clk_delay_total <= 16'h0;
            link_realign <= 1'b0;
            window_step_fine <= 1'b0;
        end
        else if (clk_en)
        begin
            sample_rise_en <= 1'b1; // R1
            sample_fall_en <= !ctrl[CTRL_DUAL]; // R2
            clk_delay_invert <= ctrl[CTRL_INV]; // R8
            clk_delay_fine <= delay[DELAY_FINE_LSB +: CODE_W]; // R9
            clk_delay_total <= next_total; // R11
            link_realign <= next_realign;
            window_step_fine <= ctrl[CTRL_STEP_FINE]; // R23
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence invert_rise_s;
        clk_en && $rose(ctrl[CTRL_INV]) && $stable(delay);
    endsequence
    sequence half_added_s;
        clk_delay_total == 16'($past(clk_delay_total) + TAD_HALF_UNIT);
    endsequence

    dual_rise_only_a: assert property (clk_en && ctrl[CTRL_DUAL] // R1
        |=> sample_rise_en && !sample_fall_en) else $error("Dual mode fall edge");
    single_both_a: assert property (clk_en && !ctrl[CTRL_DUAL] // R2
        |=> sample_rise_en && sample_fall_en) else $error("Single mode edge missing");
    invert_half_a: assert property (invert_rise_s ##0 clk_en && !ramp_busy // R8
        && $stable(clk_delay_coarse) |=> half_added_s) else $error("Invert delay wrong");
    realign_pulse_a: assert property ($changed(clk_delay_total) // R12
        |-> link_realign) else $error("Delay change without realign");
    end_flags_a: assert property (flags_valid // R22
        |-> flags[0] && flags[PHASES-1]) else $error("End flags not set");
    valid_count_a: assert property (flags_valid // R17
        |-> edge_cnt == 2'(MIN_SYSREF_EDGES)) else $error("Flags valid too early");
    capture_path_a: assert property (clk_en && sysref_edge // R19
        |=> sysref_capture == $past(tap_s2[ctrl[CTRL_SEL_LSB +: SEL_W]]))
        else $error("Capture through wrong phase");
    safe_flag_a: assert property (clk_en && sysref_edge && (tap_s2[7:5] == 3'h0 // R18
        || tap_s2[7:5] == 3'h7) && tap_last[6] == tap_s2[6] |=> !flags[6])
        else $error("Safe phase flagged");
    step_field_a: assert property (clk_en // R23
        |=> window_step_fine == $past(ctrl[CTRL_STEP_FINE])) else $error("Step select lost");
endmodule // scd_top
`default_nettype wire

/* File: scd_sysref_src.sv */
// Behavioural external clock source: drives SYSREF and the delayed taps.
// Assumes the bench commands single pulses or a periodic run.
`timescale 1ns/100ps
`default_nettype none
module scd_sysref_src
    import scd_pkg::*;
(
    input wire logic fire,
    input wire logic run,
    input wire logic [NUM_PHASES-1:0] pattern,
    output logic sysref_in,
    output logic [NUM_PHASES-1:0] taps
);
    // Period is a whole multiple of the multiframe clock
    localparam int PERIOD_NS = 4000;
    // Idle levels before any SYSREF
    initial
    begin
        sysref_in = 1'b0;
        taps = '0;
    end
    // One SYSREF pulse, taps settled around the rising edge
    // Non-blocking so edges never race the sampling clock edge
    task automatic pulse();
        taps <= pattern;
        #100;
        sysref_in <= 1'b1;
        #500;
        sysref_in <= 1'b0;
        taps <= '0;
    endtask
    // Single pulse on command, or periodic SYSREF while run is high
    always
    begin
        wait (fire === 1'b1 || run === 1'b1);
        pulse();
        if (run === 1'b1)
            #(PERIOD_NS - 600);
    end
endmodule // scd_sysref_src
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for scd_top with a behavioural SYSREF source.
// Assumes scd_pkg and scd_sysref_src are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import scd_pkg::*;
;
    logic sys_clk = 1'b0; // 20 MHz clock
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, fire = 0, run = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv, c, d, v;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    logic sample_rise_en, sample_fall_en, clk_delay_invert, link_realign;
    logic window_step_fine, sysref_capture, sysref_in;
    logic [7:0] clk_delay_coarse, clk_delay_fine;
    logic [15:0] clk_delay_total, tot, prev_tot = '0;
    logic [23:0] sysref_taps, pattern = '0, old_pat;
    logic [31:0] seed = 32'h00000052; // Fixed seed
    int compares = 0, n_fail = 0, cap_cnt = 0, re_cnt = 0, k;
    scd_top DUT (.*);
    scd_sysref_src SRC (.fire(fire), .run(run), .pattern(pattern), .sysref_in(sysref_in),
        .taps(sysref_taps));
    // Clock
    always #25 sys_clk = ~sys_clk;
    // Count capture pulses and realign pulses
    always @(posedge sys_clk)
    begin
        if (sysref_capture === 1'b1) cap_cnt++;
        if (link_realign === 1'b1) re_cnt++;
    end
    // Xorshift source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected flags: neighbour disagreement or change, ends forced
    function automatic logic [23:0] exp_flags(input logic [23:0] p, input logic [23:0] q);
        logic [23:0] f;
        f = p ^ q;
        for (int i = 1; i < 23; i++)
            f[i] = f[i] | (p[i] != p[i-1]) | (p[i] != p[i+1]);
        f[0] = 1'b1;
        f[23] = 1'b1;
        return f;
    endfunction
    // Expected total delay in fine units
    function automatic logic [15:0] exp_total(input logic inv, input logic [15:0] dl);
        return (inv ? 16'h1000 : 16'h0000) + {4'h0, dl[7:0], 4'h0} + {8'h00, dl[15:8]};
    endfunction
    // Comparison with report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // AXI4-Lite write, both channels offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] dat);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                br = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // AXI4-Lite read into rdv and rr
    task automatic rd(input logic [3:0] a);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                rdv = s_axi_rdata;
                rr = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // One SYSREF pulse, then let detection settle
    task automatic shot();
        @(posedge sys_clk);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        cyc(30);
    endtask
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog against hangs
    initial
    begin
        cyc(20000);
        n_fail++;
        stop_test();
    end
    // Main sequence
    initial
    begin
        cyc(5);
        rst_n <= 1'b1;
        cyc(2);
        chk("rise_en", 1, sample_rise_en);
        chk("fall_en", 0, sample_fall_en);
        rd(REG_CTRL);
        chk("ctrl_rst", 32'h001, rdv);
        rd(4'h2);
        chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rr});
        // Random modes and delays with the ramp off
        repeat (6)
        begin
            k = re_cnt;
            v = xs();
            c = v & 32'h00000f1b;
            d = xs() & 32'h0000ffff;
            wr(REG_CTRL, c);
            chk("bresp", {30'h0, RESP_OKAY}, {30'h0, br});
            wr(REG_DELAY, d);
            cyc(5);
            tot = exp_total(c[1], d[15:0]);
            chk("fall_en", !c[0], sample_fall_en);
            chk("invert", c[1], clk_delay_invert);
            chk("step", c[4], window_step_fine);
            chk("coarse", d[7:0], clk_delay_coarse);
            chk("fine", d[15:8], clk_delay_fine);
            chk("total", tot, clk_delay_total);
            chk("realign", 1, (re_cnt != k) || (tot == prev_tot));
            prev_tot = tot;
            rd(REG_CTRL);
            chk("ctrl_rd", c, rdv);
        end
        // Window detector
        v = xs();
        pattern <= (v[23:0] | 24'h000020) & 24'hfffdff;
        wr(REG_CTRL, 32'h501);
        k = cap_cnt;
        shot();
        shot();
        rd(REG_STATUS);
        chk("two_edges", 3'b100, rdv[11:9]);
        shot();
        rd(REG_STATUS);
        chk("valid", 3'b111, rdv[11:9]);
        rd(REG_FLAGS);
        chk("flags", {8'h00, exp_flags(pattern, pattern)}, rdv);
        chk("capture", k + 3, cap_cnt);
        wr(REG_CTRL, 32'h901);
        k = cap_cnt;
        shot();
        chk("cap_zero", k, cap_cnt);
        old_pat = pattern;
        v = xs();
        pattern <= v[23:0];
        shot();
        rd(REG_FLAGS);
        chk("unstable", {8'h00, exp_flags(pattern, old_pat)}, rdv);
        wr(REG_CTRL, 32'h501);
        pattern <= 24'h0000f0;
        k = cap_cnt;
        run <= 1'b1;
        cyc(400);
        run <= 1'b0;
        cyc(100);
        chk("periodic", 1, cap_cnt - k >= 5);
        // Ramp: fast, slow, retarget, then direct
        wr(REG_DELAY, 32'h0);
        wr(REG_CTRL, 32'h00d);
        wr(REG_DELAY, 32'h0a);
        cyc(500);
        chk("fast_mid", 4, clk_delay_coarse);
        rd(REG_STATUS);
        chk("busy", 9'h104, rdv[8:0]);
        cyc(800);
        rd(REG_STATUS);
        chk("fast_end", 9'h00a, rdv[8:0]);
        wr(REG_CTRL, 32'h005);
        wr(REG_DELAY, 32'h07);
        cyc(500);
        chk("slow_mid", 9, clk_delay_coarse);
        cyc(1000);
        chk("slow_end", 7, clk_delay_coarse);
        wr(REG_CTRL, 32'h00d);
        wr(REG_DELAY, 32'h1e);
        cyc(500);
        chk("retgt_a", 11, clk_delay_coarse);
        wr(REG_DELAY, 32'h08);
        cyc(300);
        chk("retgt_b", 11, clk_delay_coarse);
        cyc(200);
        chk("retgt_c", 8, clk_delay_coarse);
        wr(REG_CTRL, 32'h001);
        wr(REG_DELAY, 32'hc8);
        cyc(5);
        chk("direct", 8'hc8, clk_delay_coarse);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
